/* File: hw/vscp_top.sv */
// Purpose: serial volume control port with mute, calibration and zero-cross gating
// Assumes: serial clock far slower than clk (64 ns vs 8 ns)
// Notes:   pin edges found by sampling; adds about three clk of latency
// Notes:   one timeout counter serves both the update wait and the mute wait
`timescale 1ns/10ps
`default_nettype none
module vscp_top
    import vscp_pkg::*;
#(
    parameter int CAL_COUNT = CAL_CYCLES,
    parameter int ZC_COUNT  = ZC_TIMEOUT_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    // serial link pins
    input  wire logic        chip_select_n,
    input  wire logic        serial_clock,
    input  wire logic        serial_word_in,
    output logic             chain_word_out,
    output logic             chain_word_out_oe,
    // control pins
    input  wire logic        mute_n,
    input  wire logic        zero_cross_gate_enable,
    input  wire logic        zero_cross_seen,
    // channel control
    output logic [7:0]       left_channel_output,
    output logic [7:0]       right_channel_output,
    output logic             left_muted,
    output logic             right_muted,
    output logic             calibrating
);

    typedef enum logic [2:0] {
        ST_RUN     = 3'b001,
        ST_MUTE_WT = 3'b010,
        ST_MUTED   = 3'b100
    } vscp_mute_e;

    typedef struct packed {
        logic [1:0]        cs_h;
        logic [1:0]        sck_h;
        logic              mute_h;
        logic [15:0]       shift;
        logic [15:0]       volume;
        logic              pend;
        vscp_level_s       active;
        vscp_pin_s         chain;
        vscp_mute_e        mstate;
        logic [31:0]       zc_cnt;
        logic [31:0]       cal_cnt;
        logic              cal;
    } vscp_state_s;

    vscp_state_s st_reg;
    vscp_state_s st_next;
    logic [4:0]  pins;
    logic        apply_now;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisation; chip select and mute idle high
    vscp_sync #(
        .WIDTH (5)
    ) u_sync (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .async_in  ({chip_select_n, serial_clock, serial_word_in, mute_n, zero_cross_gate_enable}),
        .reset_val (PIN_IDLE),
        .sync_out  (pins)
    );

    ////////////////////////////////////////////////////////////////////
    function automatic logic fell(input logic [1:0] h);
        return h == 2'b10;
    endfunction

    function automatic logic rose(input logic [1:0] h);
        return h == 2'b01;
    endfunction

    function automatic logic [31:0] bump(input logic [31:0] cnt);
        return cnt + 32'd1;
    endfunction

    // both waits share one limit test so they time out alike
    function automatic logic expired(input logic [31:0] cnt, input int lim);
        return cnt >= 32'(lim - 1);
    endfunction

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_next        = st_reg;
        st_next.cs_h   = {st_reg.cs_h[0], pins[4]};
        st_next.sck_h  = {st_reg.sck_h[0], pins[3]};
        st_next.mute_h = pins[1];
        apply_now      = !pins[0] || zero_cross_seen || expired(st_reg.zc_cnt, ZC_COUNT);

        // the newest sample ends the drive, so the start edge is never overridden
        if (fell(st_reg.cs_h))
        begin
            st_next.chain.oe = 1'b1;
        end
        else if (st_reg.cs_h[0])
        begin
            st_next.chain.oe = 1'b0;
        end
        // bits past sixteen push the oldest out; only the last word counts
        if (!st_reg.cs_h[1] && rose(st_reg.sck_h))
        begin
            st_next.shift = {st_reg.shift[14:0], pins[2]};
        end
        // the bit taken sixteen rises ago feeds the next device in the chain
        if (!st_reg.cs_h[1] && fell(st_reg.sck_h))
        begin
            st_next.chain.data = st_reg.shift[WORD_BITS-1];
        end

        // level update: gated by crossing or timeout, or immediate
        if (st_reg.pend)
        begin
            st_next.zc_cnt = bump(st_reg.zc_cnt);
            if (apply_now)
            begin
                st_next.active.right = st_reg.volume[RIGHT_LSB +: 8];
                st_next.active.left  = st_reg.volume[LEFT_LSB +: 8];
                st_next.pend         = 1'b0;
            end
        end

        // latch after the apply step so a word taken during a crossing still wins
        if (rose(st_reg.cs_h))
        begin
            st_next.volume = st_reg.shift;
            st_next.pend   = 1'b1;
            st_next.zc_cnt = '0;
        end

        // calibration starts as mute falls and runs up to CAL_COUNT clk while mute is held low
        if (st_reg.mute_h && !pins[1])
        begin
            st_next.cal     = 1'b1;
            st_next.cal_cnt = '0;
        end
        else if (st_reg.cal)
        begin
            // counts clk alone; no serial clock is needed to calibrate
            st_next.cal_cnt = bump(st_reg.cal_cnt);
            // short mute aborts: host owes the minimum low time
            if (pins[1] || expired(st_reg.cal_cnt, CAL_COUNT))
            begin
                st_next.cal = 1'b0;
            end
        end

        case (st_reg.mstate)
            ST_RUN:
            begin
                if (!pins[1])
                begin
                    st_next.mstate = ST_MUTE_WT;
                    st_next.zc_cnt = '0;
                end
            end
            ST_MUTE_WT:
            begin
                // a mute during a pending update restarts the shared counter
                st_next.zc_cnt = bump(st_reg.zc_cnt);
                if (pins[1])
                begin
                    st_next.mstate = ST_RUN;
                end
                else if (zero_cross_seen || expired(st_reg.zc_cnt, ZC_COUNT))
                begin
                    st_next.mstate = ST_MUTED;
                end
            end
            ST_MUTED:
            begin
                if (pins[1])
                begin
                    st_next.mstate = ST_RUN;
                end
            end
            default:
            begin
                st_next.mstate = ST_RUN;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // synchronous reset; clk_en low holds every field
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_reg        <= '0;
            st_reg.cs_h   <= 2'b11;
            st_reg.mute_h <= 1'b1;
            st_reg.volume <= VOLUME_RESET;
            st_reg.mstate <= ST_RUN;
        end
        else if (clk_en)
        begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign chain_word_out       = st_reg.chain.data;
    assign chain_word_out_oe    = st_reg.chain.oe;
    assign left_channel_output  = st_reg.active.left;
    assign right_channel_output = st_reg.active.right;
    // mute is a flag beside the level codes, not a forced zero code
    assign left_muted           = st_reg.mstate == ST_MUTED;
    assign right_muted          = st_reg.mstate == ST_MUTED;
    assign calibrating          = st_reg.cal;
endmodule // vscp_top
`default_nettype wire

/* File: hw/vscp_pkg.sv */
// Purpose: shared constants and carriers for the volume serial control port
// Assumes: clk at 125 MHz; link pins sampled by clk
// Notes:   all counts derived from printed times
// Function
// - chain output bit changes on serial clock falling edge.
// - chain output is high impedance while chip select is high.
// - chip select falling edge starts a new 16-bit word.
// - chip select rising edge moves all 16 shifted bits to volume register.
// - mute low forces both channel outputs to muted ground; here both muted flags are set and the level codes are kept.
// - mute falling edge starts internal offset calibration.
// - zero-cross enable high defers level changes to crossing or timeout.
// - first eight bits set right channel, next eight set left.
// - serial data sampled on each serial clock rising edge in frame.
// - chain output presents previous sixteen bits, one word delayed.
// - hardware mute applies at zero crossing or after 18 ms timeout.
package vscp_pkg;
    localparam int          WORD_BITS        = 16;
    localparam int          CLK_MHZ          = 125;
    localparam int          CAL_TIME_US      = 2000;
    localparam int          ZC_TIMEOUT_US    = 18000;
    localparam int          CAL_CYCLES       = CAL_TIME_US * CLK_MHZ;
    localparam int          ZC_TIMEOUT_CYCLES = ZC_TIMEOUT_US * CLK_MHZ;
    localparam logic [15:0] VOLUME_RESET     = 16'h0000;
    localparam logic [4:0]  PIN_IDLE         = 5'h12;
    localparam int          RIGHT_LSB        = 8;
    localparam int          LEFT_LSB         = 0;

    typedef struct packed {
        logic [7:0] right;
        logic [7:0] left;
    } vscp_level_s;

    typedef struct packed {
        logic       data;
        logic       oe;
    } vscp_pin_s;
endpackage : vscp_pkg

/* File: hw/vscp_sync.sv */
// Purpose: two-flop synchroniser for a bus of pin inputs
// Assumes: inputs asynchronous to clk
// Notes:   first stage read only by second stage
`timescale 1ns/10ps
`default_nettype none
module vscp_sync #(
    parameter int WIDTH = 4
) (
    // clock
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] reset_val,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_reg <= reset_val;
            sync_reg <= reset_val;
        end
        else if (clk_en)
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    // flops start at the pins' idle levels so no false edge follows reset
    assign sync_out = sync_reg;
endmodule // vscp_sync
`default_nettype wire

/* File: verification/vscp_properties.sv */
// Purpose: port checks for vscp_top
// Assumes: pins change off clk edges
// Notes:   windows sized for short counts
`timescale 1ns/10ps
`default_nettype none
module vscp_properties #(
    parameter int CAL_COUNT = 20,
    parameter int ZC_COUNT  = 30
) (
    // clock and pins
    input wire logic       clk, sys_rst, clk_en, chip_select_n, serial_clock,
    input wire logic       serial_word_in, chain_word_out, chain_word_out_oe,
    input wire logic       mute_n, zero_cross_gate_enable, zero_cross_seen,
    // levels
    input wire logic [7:0] left_channel_output, right_channel_output,
    input wire logic       left_muted, right_muted, calibrating
);
    logic       sclk_q;
    logic [3:0] fall_age;
    int         low_age;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    // fall_age saturates so a long idle never wraps into the window; low_age just counts
    always_ff @(posedge clk)
    begin
        sclk_q   <= serial_clock;
        fall_age <= sys_rst ? 4'hf : (sclk_q && !serial_clock) ? 4'h0 : fall_age + {3'h0, fall_age != 4'hf};
        low_age  <= (sys_rst || mute_n) ? 0 : low_age + 1;
    end
    chain_hiz_a: assert property (chip_select_n [*6] |-> !chain_word_out_oe)
        else $error("chain pin driven while deselected");
    frame_start_a: assert property ($fell(chip_select_n) |-> ##[2:6] chain_word_out_oe)
        else $error("chain pin not driven in frame");
    chain_edge_a: assert property ($changed(chain_word_out) && chain_word_out_oe && $past(chain_word_out_oe)
        |-> fall_age inside {[4'h2:4'h7]}) else $error("chain bit moved off falling edge");
    hold_frame_a: assert property ((!chip_select_n && !zero_cross_gate_enable) [*8]
        |-> $stable({left_channel_output, right_channel_output})) else $error("level moved mid frame");
    mute_pair_a: assert property (left_muted == right_muted)
        else $error("channels muted apart");
    unmute_a: assert property (mute_n [*5] |-> !left_muted)
        else $error("muted without mute pin");
    cal_start_a: assert property ($fell(mute_n) |-> ##[2:5] calibrating)
        else $error("calibration not started");
    cal_len_a: assert property (calibrating |-> low_age <= CAL_COUNT + 5)
        else $error("calibration overran");
    mute_late_a: assert property (low_age > ZC_COUNT + 8 |-> left_muted)
        else $error("mute timeout missed");
    cover property ($rose(chip_select_n));
    cover property ($rose(left_muted));
    cover property ($fell(calibrating));
endmodule // vscp_properties
bind vscp_top vscp_properties #(.CAL_COUNT(CAL_COUNT), .ZC_COUNT(ZC_COUNT)) chk_u (.clk, .sys_rst,
    .clk_en, .chip_select_n, .serial_clock, .serial_word_in, .chain_word_out, .chain_word_out_oe,
    .mute_n, .zero_cross_gate_enable, .zero_cross_seen, .left_channel_output,
    .right_channel_output, .left_muted, .right_muted, .calibrating);
`default_nettype wire

/* File: verification/vscp_host_model.sv */
// Purpose: host side of the serial link
// Assumes: 64 ns serial clock, edges off clk
// Notes:   echo holds the chain bits read in the last frame
`timescale 1ns/10ps
`default_nettype none
module vscp_host_model (
    // link pins
    output logic           chip_select_n, serial_clock, serial_word_in,
    input  wire logic      chain_word_out, chain_word_out_oe,
    // read back
    output logic [15:0]    echo
);
    initial
    begin
        chip_select_n  = 1'b1;
        serial_clock   = 1'b0;
        serial_word_in = 1'b0;
        echo           = 16'h0000;
    end
    // clock stands still between frames; chain read just before the next fall, where it is settled
    task automatic send(input logic [15:0] w);
        #3 chip_select_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            serial_word_in = w[i];
            #32 serial_clock = 1'b1;
            #32 echo = {echo[14:0], chain_word_out_oe ? chain_word_out : 1'bx};
            serial_clock = 1'b0;
        end
        #32;
        chip_select_n  = 1'b1;
        serial_word_in = ~serial_word_in;
        #32;
    endtask
endmodule // vscp_host_model
`default_nettype wire

/* File: verification/vscp_top_tb_top.sv */
// Purpose: self-checking bench for vscp_top
// Assumes: short counts CAL 20, ZC 30
// Notes:   clk_en held high
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin errors++; $display("Error %s expected %h seen %h", n, e, a); end end
module vscp_top_tb_top;
    localparam int CAL = 20;
    localparam int ZC  = 30;
    logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, mute_n = 1'b1;
    logic zero_cross_gate_enable = 1'b0, zero_cross_seen = 1'b0;
    wire logic chip_select_n, serial_clock, serial_word_in, chain_word_out, chain_word_out_oe;
    wire logic left_muted, right_muted, calibrating;
    wire logic [7:0] left_channel_output, right_channel_output;
    wire logic [15:0] echo;
    wire logic [15:0] lv = {right_channel_output, left_channel_output};
    int errors = 0, tests_run = 0, cyc = 0;
    always #4 clk = ~clk;
    vscp_top #(.CAL_COUNT(CAL), .ZC_COUNT(ZC)) dut_u (.clk, .sys_rst, .clk_en, .chip_select_n,
        .serial_clock, .serial_word_in, .chain_word_out, .chain_word_out_oe, .mute_n,
        .zero_cross_gate_enable, .zero_cross_seen, .left_channel_output, .right_channel_output,
        .left_muted, .right_muted, .calibrating);
    vscp_host_model host_u (.chip_select_n, .serial_clock, .serial_word_in, .chain_word_out,
        .chain_word_out_oe, .echo);
    ////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse_zc;
        @(posedge clk) zero_cross_seen <= 1'b1;
        @(posedge clk) zero_cross_seen <= 1'b0;
        tick(2);
    endtask
    task automatic t_word;
        `CHK("oe", 1'b0, chain_word_out_oe)
        host_u.send(16'h5AC3);
        tick(2);
        `CHK("right", 8'h5A, right_channel_output)
        `CHK("left", 8'hC3, left_channel_output)
        host_u.send(16'h0FF0);
        `CHK("chain", 16'h5AC3, echo)
        tick(2);
        `CHK("levels", 16'h0FF0, lv)
        $display("word test done");
    endtask
    task automatic t_gate;
        @(posedge clk) zero_cross_gate_enable <= 1'b1;
        tick(4);
        host_u.send(16'h8001);
        tick(10);
        `CHK("held", 16'h0FF0, lv)
        pulse_zc();
        `CHK("crossed", 16'h8001, lv)
        host_u.send(16'h7F7E);
        tick(10);
        `CHK("waiting", 16'h8001, lv)
        tick(ZC);
        `CHK("timed out", 16'h7F7E, lv)
        @(posedge clk) zero_cross_gate_enable <= 1'b0;
        $display("gate test done");
    endtask
    task automatic t_mute;
        @(posedge clk) mute_n <= 1'b0;
        tick(6);
        `CHK("cal", 1'b1, calibrating)
        `CHK("early", 1'b0, left_muted)
        pulse_zc();
        `CHK("mute zc", 2'b11, {left_muted, right_muted})
        tick(CAL);
        `CHK("cal end", 1'b0, calibrating)
        @(posedge clk) mute_n <= 1'b1;
        tick(6);
        `CHK("unmute", 2'b00, {left_muted, right_muted})
        @(posedge clk) mute_n <= 1'b0;
        tick(ZC + 10);
        `CHK("mute timeout", 2'b11, {left_muted, right_muted})
        @(posedge clk) mute_n <= 1'b1;
        tick(6);
        $display("mute test done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            errors++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        tick(6);
        t_word();
        t_gate();
        t_mute();
        report_and_stop();
    end
endmodule // vscp_top_tb_top
`default_nettype wire
